// >>> rtl/ocl_map.svh
// Offsets, field positions, reset values and counts for the channel control slice.
// Assumes inclusion by bare name from any design file of this block.
// Notes on behaviour
// - Select-A code 000..101 in bits 6..4 picks a count rate of clock/1, /2, /4, /8, /16 or /32 for side A.
// - Select-B code 000..101 in bits 2..0 picks a count rate of clock/1, /2, /4, /8, /16 or /32 for side B.
// - Both selects reset to zero, so counting starts undivided, and bits 7 and 3 read zero and ignore writes.
// - Link bit n (0..5) passes channel output n through to channel-1 offset source n, else blocks it.
// - Link bit 6 passes channel output G through to channel-2 offset source A, else blocks it.
// - Link bit 7 passes channel output H through to channel-2 offset source B, else blocks it.
// - All eight link bits reset to zero and are all freely readable and writable.
// - The one-shot H request is forwarded only while enable bit 7 is one.
// - All eight one-shot enables, H..A in bits 7..0, reset to zero.
// - One-shot G, F, E and D requests are gated by enable bits 6, 5, 4 and 3.
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH

// Processor-side register addresses
`define OCL_PRESCALE_OFS 32'hffff82e0
`define OCL_LINK_OFS 32'hffff82e1
`define OCL_IRQEN_OFS 32'hffff82e2

// Register indices; byte address is four times the index
`define OCL_PRESCALE_IDX 6'h00
`define OCL_LINK_IDX 6'h01
`define OCL_IRQEN_IDX 6'h02
`define OCL_STATUS_IDX 6'h03

// Field positions
`define OCL_SEL_A_LSB 4
`define OCL_SEL_A_MSB 6
`define OCL_SEL_B_LSB 0
`define OCL_SEL_B_MSB 2
`define OCL_PRESCALE_WMASK 8'h77

// Reset values
`define OCL_PRESCALE_RST 8'h00
`define OCL_LINK_RST 8'h00
`define OCL_IRQEN_RST 8'h00
`define OCL_STATUS_RST 8'h00

// Prescaler counter width, enough for divide by 32
`define OCL_CNT_W 5

`endif

// >>> rtl/ocl_pkg.sv
// Types shared by the channel control slice.
// Assumes nothing beyond a SystemVerilog compiler.
package ocl_pkg;

	// Prescaler select codes, divide ratio rising with the code
	typedef enum logic [2:0] {
		ocl_div_1,
		ocl_div_2,
		ocl_div_4,
		ocl_div_8,
		ocl_div_16,
		ocl_div_32,
		ocl_div_rsv6,
		ocl_div_rsv7
	} ocl_div_t;

	typedef logic [7:0] ocl_byte_t;
	typedef logic [5:0] ocl_idx_t;

endpackage

// >>> rtl/ocl_pre_if.sv
// Select and tick pair between the top and one prescaler.
// Assumes both ends sit on clk_sys.
interface ocl_pre_if;
	ocl_pkg::ocl_div_t sel;
	logic tick;

	modport ctrl (output sel, input tick);
	modport div (input sel, output tick);
endinterface

// >>> rtl/ocl_prescaler.sv
// One prescaler: a free counter and a registered count tick per selected rate.
// Assumes sel comes from a register on the same clock.
`include "ocl_map.svh"

module ocl_prescaler #(
	parameter int CNT_W = `OCL_CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Select in, tick out
	ocl_pre_if.div pre
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;
	logic [CNT_W-1:0] mask;
	logic valid;

	// Low-bit mask per rate; reserved codes never tick
	always_comb begin
		mask = '0;
		valid = 1'b1;
		unique case (pre.sel)
			ocl_pkg::ocl_div_1: mask = 5'h00;
			ocl_pkg::ocl_div_2: mask = 5'h01;
			ocl_pkg::ocl_div_4: mask = 5'h03;
			ocl_pkg::ocl_div_8: mask = 5'h07;
			ocl_pkg::ocl_div_16: mask = 5'h0f;
			ocl_pkg::ocl_div_32: mask = 5'h1f;
			ocl_pkg::ocl_div_rsv6: valid = 1'b0;
			ocl_pkg::ocl_div_rsv7: valid = 1'b0;
		endcase
		cnt_next = cnt_reg + 5'h01;
		tick_next = valid && ((cnt_reg & mask) == mask);
	end

	// Counter and tick flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign pre.tick = tick_reg;

endmodule

// >>> rtl/ocl_top.sv
// Channel control slice: prescaler selects, output-to-offset links, one-shot interrupt gating.
// Assumes a classic Wishbone master on clk_sys and same-clock channel and flag inputs.
//
// Added by the designer: the Wishbone register port.
`include "ocl_map.svh"

module ocl_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// Count rate ticks
	output logic count_tick_a,
	output logic count_tick_b,
	// Channel outputs H..A and offset sources
	input wire logic [7:0] chan_out,
	output logic [5:0] ch1_offset_src,
	output logic ch2_offset_src_a,
	output logic ch2_offset_src_b,
	// One-shot flags H..A and requests
	input wire logic [7:0] oneshot_flag,
	output logic [7:0] oneshot_irq,
	output logic irq
);

	// Prescaler carriers
	ocl_pre_if pre_a ();
	ocl_pre_if pre_b ();

	// Bus state
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic stat_rd_reg;
	logic stat_rd_next;

	// Register state
	ocl_pkg::ocl_byte_t prescaler_select_reg;
	ocl_pkg::ocl_byte_t prescaler_select_next;
	ocl_pkg::ocl_byte_t output_link_enables_reg;
	ocl_pkg::ocl_byte_t output_link_enables_next;
	ocl_pkg::ocl_byte_t one_shot_irq_enables_reg;
	ocl_pkg::ocl_byte_t one_shot_irq_enables_next;
	ocl_pkg::ocl_byte_t status_reg;
	ocl_pkg::ocl_byte_t status_next;
	ocl_pkg::ocl_byte_t flag_prev_reg;
	ocl_pkg::ocl_byte_t flag_prev_next;

	// Output state
	logic [5:0] ch1_src_reg;
	logic [5:0] ch1_src_next;
	logic ch2_a_reg;
	logic ch2_a_next;
	logic ch2_b_reg;
	logic ch2_b_next;
	ocl_pkg::ocl_byte_t oneshot_irq_reg;
	ocl_pkg::ocl_byte_t oneshot_irq_next;
	logic irq_reg;
	logic irq_next;

	// Decode and strobes
	ocl_pkg::ocl_idx_t idx;
	logic req;
	logic wr_fire;
	logic rd_fire;
	logic hit_pre;
	logic hit_link;
	logic hit_en;
	logic hit_stat;
	ocl_pkg::ocl_byte_t wbyte;
	ocl_pkg::ocl_byte_t rise;
	ocl_pkg::ocl_byte_t clr;

	// Prescaler selects from the control register
	assign pre_a.sel = ocl_pkg::ocl_div_t'(prescaler_select_reg[`OCL_SEL_A_MSB:`OCL_SEL_A_LSB]);
	assign pre_b.sel = ocl_pkg::ocl_div_t'(prescaler_select_reg[`OCL_SEL_B_MSB:`OCL_SEL_B_LSB]);

	// Side A prescaler
	ocl_prescaler #(
		.CNT_W(`OCL_CNT_W)
	) u_pre_a (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pre(pre_a)
	);

	// Side B prescaler
	ocl_prescaler #(
		.CNT_W(`OCL_CNT_W)
	) u_pre_b (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pre(pre_b)
	);

	// Address decode; byte lanes above lane 0 are ignored
	always_comb begin
		idx = ocl_pkg::ocl_idx_t'(wb_adr[7:2]);
		req = wb_cyc && wb_stb;
		hit_pre = (idx == `OCL_PRESCALE_IDX);
		hit_link = (idx == `OCL_LINK_IDX);
		hit_en = (idx == `OCL_IRQEN_IDX);
		hit_stat = (idx == `OCL_STATUS_IDX);
		wr_fire = req && wb_we && ack_reg && wb_sel[0]; // Write lands at the ack edge
		rd_fire = req && !wb_we && ack_reg;
		wbyte = wb_dat_w[7:0];
	end

	// Ack one cycle after the request, dropped right after
	always_comb begin
		ack_next = req && !ack_reg;
		stat_rd_next = 1'b0;
		dat_next = 32'h00000000;
		if (req && !ack_reg && !wb_we) begin
			stat_rd_next = hit_stat;
			if (hit_pre) begin
				dat_next = {24'h000000, prescaler_select_reg};
			end else if (hit_link) begin
				dat_next = {24'h000000, output_link_enables_reg};
			end else if (hit_en) begin
				dat_next = {24'h000000, one_shot_irq_enables_reg};
			end else if (hit_stat) begin
				dat_next = {24'h000000, status_reg};
			end else begin
				dat_next = 32'h00000000; // Unmapped reads zero
			end
		end
	end

	// Bus flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
			stat_rd_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			stat_rd_reg <= stat_rd_next;
		end
	end

	// Prescaler select register; bits 7 and 3 stay zero
	always_comb begin
		prescaler_select_next = prescaler_select_reg;
		if (wr_fire && hit_pre) begin
			prescaler_select_next = wbyte & `OCL_PRESCALE_WMASK;
		end
	end

	// Link enable register
	always_comb begin
		output_link_enables_next = output_link_enables_reg;
		if (wr_fire && hit_link) begin
			output_link_enables_next = wbyte;
		end
	end

	// One-shot enable register, also the interrupt mask
	always_comb begin
		one_shot_irq_enables_next = one_shot_irq_enables_reg;
		if (wr_fire && hit_en) begin
			one_shot_irq_enables_next = wbyte;
		end
	end

	// Control register flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prescaler_select_reg <= `OCL_PRESCALE_RST;
			output_link_enables_reg <= `OCL_LINK_RST;
			one_shot_irq_enables_reg <= `OCL_IRQEN_RST;
		end else begin
			prescaler_select_reg <= prescaler_select_next;
			output_link_enables_reg <= output_link_enables_next;
			one_shot_irq_enables_reg <= one_shot_irq_enables_next;
		end
	end

	// Sticky one-shot events; a read clears only the bits it returned
	always_comb begin
		flag_prev_next = oneshot_flag;
		rise = oneshot_flag & ~flag_prev_reg;
		clr = 8'h00;
		if (rd_fire && stat_rd_reg) begin
			clr = dat_reg[7:0];
		end
		status_next = (status_reg & ~clr) | rise; // Set wins over clear
	end

	// Event flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= `OCL_STATUS_RST;
			flag_prev_reg <= 8'h00;
		end else begin
			status_reg <= status_next;
			flag_prev_reg <= flag_prev_next;
		end
	end

	// Output-to-offset couplings
	always_comb begin
		ch1_src_next = chan_out[5:0] & output_link_enables_reg[5:0];
		ch2_a_next = chan_out[6] && output_link_enables_reg[6];
		ch2_b_next = chan_out[7] && output_link_enables_reg[7];
	end

	// Coupling flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ch1_src_reg <= 6'h00;
			ch2_a_reg <= 1'b0;
			ch2_b_reg <= 1'b0;
		end else begin
			ch1_src_reg <= ch1_src_next;
			ch2_a_reg <= ch2_a_next;
			ch2_b_reg <= ch2_b_next;
		end
	end

	// One-shot request gating, bit per channel
	always_comb begin
		oneshot_irq_next[7] = oneshot_flag[7] && one_shot_irq_enables_reg[7];
		oneshot_irq_next[6:3] = oneshot_flag[6:3] & one_shot_irq_enables_reg[6:3];
		oneshot_irq_next[2:0] = oneshot_flag[2:0] & one_shot_irq_enables_reg[2:0];
		irq_next = |(status_reg & one_shot_irq_enables_reg);
	end

	// Request flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			oneshot_irq_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else begin
			oneshot_irq_reg <= oneshot_irq_next;
			irq_reg <= irq_next;
		end
	end

	// Port drive, all from flops
	assign wb_ack = ack_reg;
	assign wb_dat_r = dat_reg;
	assign count_tick_a = pre_a.tick;
	assign count_tick_b = pre_b.tick;
	assign ch1_offset_src = ch1_src_reg;
	assign ch2_offset_src_a = ch2_a_reg;
	assign ch2_offset_src_b = ch2_b_reg;
	assign oneshot_irq = oneshot_irq_reg;
	assign irq = irq_reg;

endmodule

// >>> testbench/ocl_assertions.sv
// Concurrent checks on the channel control slice top ports.
// Assumes one clk_sys domain and the active-low rst_b.
module ocl_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Bus
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	// Channel outputs and flags
	input wire logic [7:0] chan_out,
	input wire logic [5:0] ch1_offset_src,
	input wire logic ch2_offset_src_a,
	input wire logic ch2_offset_src_b,
	input wire logic [7:0] oneshot_flag,
	input wire logic [7:0] oneshot_irq,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Bus answer timing and read data
	AST_ACK_NEXT: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack) else $error("ack missing");
	AST_ACK_ONE: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
	AST_DAT_IDLE: assert property (!wb_ack |-> wb_dat_r == 32'h0) else $error("data outside ack");
	AST_SEL_RSV: assert property (wb_ack && $past(wb_adr[7:2] == 6'h00) |-> !wb_dat_r[7] && !wb_dat_r[3])
		else $error("reserved select bits set");
	// Links never pass a quiet output
	AST_LINK_1: assert property ((ch1_offset_src & ~$past(chan_out[5:0])) == 6'h00)
		else $error("offset source without output");
	AST_LINK_G: assert property (ch2_offset_src_a |-> $past(chan_out[6])) else $error("source a stray");
	AST_LINK_H: assert property (ch2_offset_src_b |-> $past(chan_out[7])) else $error("source b stray");
	// Requests only from a raised flag
	AST_IRQ_GATE: assert property ((oneshot_irq & ~$past(oneshot_flag)) == 8'h00)
		else $error("request without flag");
	// Main scenarios
	COV_WRITE: cover property (wb_ack && wb_we);
	COV_IRQ: cover property ($rose(irq));
	COV_LINK_H: cover property (ch2_offset_src_b);
endmodule

bind ocl_top ocl_chk u_chk (.clk_sys, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_r, .wb_ack, .chan_out,
	.ch1_offset_src, .ch2_offset_src_a, .ch2_offset_src_b, .oneshot_flag, .oneshot_irq, .irq);

// >>> testbench/ocl_top_tb.sv
// Self-checking bench for the channel control slice.
// Assumes ocl_top with its checker bound; the bench drives every port.
module ocl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rst_b = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, irq;
	logic count_tick_a, count_tick_b, ch2_offset_src_a, ch2_offset_src_b;
	logic [7:0] wb_adr = 8'h00, chan_out = 8'h00, oneshot_flag = 8'h00, oneshot_irq;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
	logic [5:0] ch1_offset_src;
	int err_total = 0, cmp_count = 0, cyc_cnt = 0;

	ocl_top uut (.clk_sys, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack,
		.count_tick_a, .count_tick_b, .chan_out, .ch1_offset_src, .ch2_offset_src_a, .ch2_offset_src_b,
		.oneshot_flag, .oneshot_irq, .irq);

	// Clock and hang guard
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic single cycle, held until ack is sampled
	task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} <= {1'b1, 1'b1, we, adr, 4'hf, 24'h0, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack !== 1'b1);
		q = wb_dat_r;
		{wb_cyc, wb_stb, wb_we} <= 3'h0;
		chk("ack wait", 32'h2, 32'(n));
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic t_reset();
		bus(1'b0, 8'h00, 8'h00);
		chk("select", 32'h0, q);
		bus(1'b0, 8'h04, 8'h00);
		chk("links", 32'h0, q);
		bus(1'b0, 8'h08, 8'h00);
		chk("enables", 32'h0, q);
		bus(1'b0, 8'h10, 8'h00);
		chk("unmapped", 32'h0, q);
		$display("reset test done");
	endtask

	task automatic t_presc();
		int na, nb;
		for (int c = 0; c < 6; c++) begin
			bus(1'b1, 8'h00, 8'((c << 4) | (5 - c) | 8'h88));
			bus(1'b0, 8'h00, 8'h00);
			chk("select rb", 32'((c << 4) | (5 - c)), q);
			na = 0;
			nb = 0;
			step(2);
			repeat (64) begin
				step(1);
				na += int'(count_tick_a === 1'b1);
				nb += int'(count_tick_b === 1'b1);
			end
			chk("ticks a", 32'(64 >> c), 32'(na));
			chk("ticks b", 32'(64 >> (5 - c)), 32'(nb));
		end
		$display("prescaler test done");
	endtask

	task automatic t_link();
		logic [7:0] tv[5] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h81};
		foreach (tv[i]) begin
			bus(1'b1, 8'h04, tv[i]);
			bus(1'b0, 8'h04, 8'h00);
			chk("links rb", {24'h0, tv[i]}, q);
			chan_out <= 8'hff;
			step(3);
			chk("ch1 src", 32'(tv[i][5:0]), 32'(ch1_offset_src));
			chk("ch2 src", 32'(tv[i][7:6]), 32'({ch2_offset_src_b, ch2_offset_src_a}));
			@(posedge clk_sys);
			chan_out <= 8'h00;
			step(3);
			chk("ch src off", 32'h0, 32'({ch2_offset_src_b, ch2_offset_src_a, ch1_offset_src}));
		end
		$display("link test done");
	endtask

	task automatic t_irq();
		bus(1'b1, 8'h08, 8'h81);
		oneshot_flag <= 8'hff;
		step(3);
		chk("req", 32'h81, 32'(oneshot_irq));
		chk("irq", 32'h1, 32'(irq));
		bus(1'b0, 8'h0c, 8'h00);
		chk("status", 32'hff, q);
		step(2);
		chk("irq cleared", 32'h0, 32'(irq));
		bus(1'b1, 8'h08, 8'h00);
		oneshot_flag <= 8'h00;
		@(posedge clk_sys);
		oneshot_flag <= 8'hff;
		step(3);
		chk("masked req", 32'h0, 32'(oneshot_irq));
		chk("masked irq", 32'h0, 32'(irq));
		bus(1'b1, 8'h08, 8'h7e);
		step(2);
		chk("req g..b", 32'h7e, 32'(oneshot_irq));
		chk("irq unmask", 32'h1, 32'(irq));
		$display("interrupt test done");
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_presc();
		t_link();
		t_irq();
		close_out();
	end
endmodule
